// ---- logic/rcd_map.svh ----
`ifndef RCD_MAP_SVH
`define RCD_MAP_SVH
// ----------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------
`define RCD_REF_CTRL 5'h00
`define RCD_REF_NOMINAL 5'h04
`define RCD_OP_STATUS 5'h08
`define RCD_LOCK_QUERY 5'h0C
`define RCD_GROUP_SEL 5'h10
`define RCD_OUT2_CTRL 5'h14
`define RCD_OUT2_STATUS 5'h18
`define RCD_RESET_CMD 5'h1C
// ----------------------------------------------------------
// field positions
// ----------------------------------------------------------
`define RCD_EXT_SEL_BIT 0
`define RCD_UNLOCKED_BIT 6
`define RCD_SETTLING_BIT 0
`define RCD_OUT_ON_BIT 0
`define RCD_DIV_LSB 8
`define RCD_ACTIVE_BIT 8
`define RCD_BASE_RST_BIT 0
`define RCD_PART_RST_BIT 1
// ----------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------
`define RCD_NOMINAL_RST 16'h2710
`define RCD_INT_REF_MHZ 10
`define RCD_BASE_MHZ 40
`define RCD_MAX_DIV 32
`define RCD_CLK_HZ 20000000
`define RCD_SETTLE_MS 1000
`define RCD_GATE_MS 1
`define RCD_WARN_MS 500
`define RCD_LOCK_TOL 16'h0002
`endif

// ---- logic/rcd_pkg.sv ----
`default_nettype none
package rcd_pkg;
    // reference tracking states
    typedef enum logic [1:0] {RCD_INT, RCD_SETTLE, RCD_TRACK} rcd_lock_e;
    // whole state of the top module
    typedef struct packed {
        logic [1:0] ext_sync;
        logic [1:0] int_sync;
        logic ext_prev;
        logic ref_ext;
        logic [15:0] nominal;
        rcd_lock_e lck;
        logic [31:0] settle_cnt;
        logic [31:0] gate_cnt;
        logic [15:0] edge_cnt;
        logic unlocked;
        logic [31:0] warn_cnt;
        logic warn;
        logic [4:0] grp_sel;
        logic [31:0] grp_on;
        logic [31:0][4:0] grp_div;
        logic [4:0] owner;
        logic out_active;
        logic ref_out1;
        logic wait_req;
        logic [31:0] rdata;
    } rcd_top_s;
    // whole state of the divider
    typedef struct packed {
        logic [4:0] cnt;
        logic [4:0] cur;
        logic level;
        logic tick;
    } rcd_div_s;
endpackage : rcd_pkg
`default_nettype wire

// ---- logic/rcd_div_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// divisor in, divided clock out
interface rcd_div_if;
    logic run;
    logic [4:0] div_m1;
    logic level;
    logic tick;
    modport ctrl (output run, output div_m1, input level, input tick);
    modport div (input run, input div_m1, output level, output tick);
endinterface : rcd_div_if
`default_nettype wire

// ---- logic/rcd_divider.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rcd_map.svh"
module rcd_divider (
    input wire logic clk_sys,
    input wire logic resetn,
    rcd_div_if.div dv
);
    import rcd_pkg::*;
    rcd_div_s s;
    rcd_div_s next_s;
    // ----------------------------------------------------------
    // divide by cur+1, high for the first half of each period
    // ----------------------------------------------------------
    function automatic logic high_part(input logic [4:0] cur, input logic [4:0] cnt);
        logic [5:0] half;
        half = (6'({1'b0, cur}) + 6'h02) >> 1;
        return 6'(cur - cnt) < half;
    endfunction : high_part
    // reload picks up a new divisor only at period end
    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        if (!dv.run)
        begin
            next_s = '0; // R9
        end
        else if (s.cnt == 5'h00)
        begin
            next_s.cur = dv.div_m1; // R13
            next_s.cnt = dv.div_m1;
            next_s.tick = 1'b1;
            next_s.level = 1'b1; // R12
        end
        else
        begin
            next_s.cnt = s.cnt - 5'h01;
            next_s.level = high_part(s.cur, s.cnt - 5'h01);
        end
    end
    // state register
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            s <= '0;
        else
            s <= next_s;
    end
    assign dv.level = s.level;
    assign dv.tick = s.tick;
    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    reload_take_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R13
        s.tick |-> s.cur == $past(dv.div_m1))
        else $error("divisor not taken at reload");
    div_one_high_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
        (dv.run && dv.div_m1 == 5'h00 && s.cnt == 5'h00)[*2] |-> s.level && s.tick)
        else $error("divide by one not steady high");
    off_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R9
        !dv.run |=> !s.level && !s.tick)
        else $error("divider runs while off");
endmodule : rcd_divider
`default_nettype wire

// ---- logic/rcd_ref_clock.sv ----
// How it works
// R1: choose internal oscillator or external reference
// R2: software gives external nominal frequency
// R3: selected reference copied to first output
// R4: lock failure sets status bit six
// R5: base reset forces internal reference
// R6: one second settling after choosing external
// R7: partial reset leaves reference selection alone
// R8: one reference setting for all groups
// R9: group off keeps another group's clock; code removes it when the off group's on bit is still set
// R10: explicit on to off removes clock
// R11: group on takes over second output
// R12: second output is base over 1..32
// R13: divisor changes at counter reload
`timescale 1ns/1ns
`default_nettype none
`include "rcd_map.svh"
module rcd_ref_clock #(
    parameter int unsigned NGROUP = 4,
    parameter int unsigned SETTLE_CYC = `RCD_SETTLE_MS * (`RCD_CLK_HZ / 1000),
    parameter int unsigned GATE_CYC = `RCD_GATE_MS * (`RCD_CLK_HZ / 1000),
    parameter int unsigned WARN_CYC = `RCD_WARN_MS * (`RCD_CLK_HZ / 1000)
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_ref_in,
    input wire logic int_osc_in,
    output logic ref_out1,
    output logic ref_out2,
    output logic ref_out2_tick,
    output logic unlock_warn,
    output logic unlocked
);
    import rcd_pkg::*;
    // ----------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------
    if (NGROUP < 1 || NGROUP > 32)
    begin : g_bad_groups
        $error("NGROUP must lie in 1..32");
    end
    if (SETTLE_CYC < 1 || GATE_CYC < 1 || WARN_CYC < 1)
    begin : g_bad_counts
        $error("timing counts must be at least one");
    end
    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    localparam rcd_top_s RST = '{wait_req: 1'b1, nominal: `RCD_NOMINAL_RST, lck: RCD_INT,
        default: '0};
    rcd_top_s s; // all registers
    rcd_top_s next_s; // their next values
    logic req; // a bus request is up
    logic acc; // request accepted this edge
    logic wr_on; // written on bit
    logic [4:0] wr_sel; // group addressed by the write
    logic ext_rise; // rising edge of the external reference
    logic [15:0] diff; // measured count minus nominal, absolute
    rcd_div_if dv ();
    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    // absolute difference, used for the lock window
    function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
        return (a > b) ? a - b : b - a;
    endfunction : absdiff
    // back to the power-on view of the base system, nominal kept
    function automatic rcd_top_s base_reset(input rcd_top_s cur);
        rcd_top_s r;
        r = RST;
        r.ext_sync = cur.ext_sync;
        r.int_sync = cur.int_sync;
        r.ext_prev = cur.ext_prev;
        r.nominal = cur.nominal;
        r.wait_req = 1'b1;
        return r;
    endfunction : base_reset
    assign req = avs_read | avs_write;
    assign acc = req && !s.wait_req;
    assign wr_on = avs_writedata[`RCD_OUT_ON_BIT];
    assign wr_sel = s.grp_sel;
    assign ext_rise = s.ext_sync[1] && !s.ext_prev;
    assign diff = absdiff(s.edge_cnt, s.nominal);
    // ----------------------------------------------------------
    // next state
    // ----------------------------------------------------------
    always_comb
    begin
        next_s = s;
        // pins pass two flops before use
        next_s.ext_sync = {s.ext_sync[0], ext_ref_in};
        next_s.int_sync = {s.int_sync[0], int_osc_in};
        next_s.ext_prev = s.ext_sync[1];
        // selected reference to the first output
        next_s.ref_out1 = s.ref_ext ? s.ext_sync[1] : s.int_sync[1]; // R3
        next_s.warn = 1'b0;
        // reference tracking, one global setting
        unique case (s.lck) // R8
            RCD_INT:
            begin
                next_s.unlocked = 1'b0;
                if (s.ref_ext)
                begin
                    next_s.lck = RCD_SETTLE;
                    next_s.settle_cnt = '0;
                end
            end
            RCD_SETTLE:
            begin
                // not yet synchronised while the loop settles
                next_s.unlocked = 1'b1;
                next_s.settle_cnt = s.settle_cnt + 32'h0000_0001; // R6
                if (s.settle_cnt == 32'(SETTLE_CYC - 1))
                begin
                    next_s.lck = RCD_TRACK;
                    next_s.gate_cnt = '0;
                    next_s.edge_cnt = '0;
                end
                if (!s.ref_ext)
                    next_s.lck = RCD_INT;
            end
            RCD_TRACK:
            begin
                // count edges in one gate, compare with nominal
                next_s.gate_cnt = s.gate_cnt + 32'h0000_0001;
                if (ext_rise && s.edge_cnt != 16'hFFFF)
                    next_s.edge_cnt = s.edge_cnt + 16'h0001;
                if (s.gate_cnt == 32'(GATE_CYC - 1))
                begin
                    next_s.unlocked = diff > `RCD_LOCK_TOL; // R2 R4
                    next_s.gate_cnt = '0;
                    next_s.edge_cnt = '0;
                end
                if (!s.ref_ext)
                    next_s.lck = RCD_INT;
            end
        endcase
        // repeating warning while unlocked
        if (s.unlocked)
        begin
            next_s.warn_cnt = s.warn_cnt + 32'h0000_0001;
            if (s.warn_cnt == 32'(WARN_CYC - 1))
            begin
                next_s.warn = 1'b1; // R4
                next_s.warn_cnt = '0;
            end
        end
        else
        begin
            next_s.warn_cnt = '0;
        end
        // bus: one wait cycle, then answer
        next_s.wait_req = 1'b1;
        if (req && s.wait_req)
        begin
            next_s.wait_req = 1'b0;
            next_s.rdata = '0; // unmapped reads zero
            unique case (avs_address)
                `RCD_REF_CTRL: next_s.rdata[`RCD_EXT_SEL_BIT] = s.ref_ext;
                `RCD_REF_NOMINAL: next_s.rdata[15:0] = s.nominal;
                `RCD_OP_STATUS:
                begin
                    next_s.rdata[`RCD_UNLOCKED_BIT] = s.unlocked; // R4
                    next_s.rdata[`RCD_SETTLING_BIT] = s.lck == RCD_SETTLE;
                end
                `RCD_LOCK_QUERY: next_s.rdata[0] = s.unlocked;
                `RCD_GROUP_SEL: next_s.rdata[4:0] = s.grp_sel;
                `RCD_OUT2_CTRL:
                begin
                    next_s.rdata[`RCD_OUT_ON_BIT] = s.grp_on[s.grp_sel];
                    next_s.rdata[`RCD_DIV_LSB +: 5] = s.grp_div[s.grp_sel];
                end
                `RCD_OUT2_STATUS:
                begin
                    next_s.rdata[4:0] = s.owner;
                    next_s.rdata[`RCD_ACTIVE_BIT] = s.out_active;
                end
                default: next_s.rdata = '0;
            endcase
        end
        // writes take effect at the accepting edge
        if (acc && avs_write)
        begin
            unique case (avs_address)
                `RCD_REF_CTRL: next_s.ref_ext = avs_writedata[`RCD_EXT_SEL_BIT]; // R1
                `RCD_REF_NOMINAL: next_s.nominal = avs_writedata[15:0]; // R2
                `RCD_GROUP_SEL:
                begin
                    // out of range picks select the last group
                    if ({1'b0, avs_writedata[4:0]} < 6'(NGROUP))
                        next_s.grp_sel = avs_writedata[4:0];
                    else
                        next_s.grp_sel = 5'(NGROUP - 1);
                end
                `RCD_OUT2_CTRL:
                begin
                    next_s.grp_div[wr_sel] = avs_writedata[`RCD_DIV_LSB +: 5]; // R12
                    next_s.grp_on[wr_sel] = wr_on;
                    if (wr_on)
                    begin
                        next_s.owner = wr_sel; // R11
                        next_s.out_active = 1'b1;
                    end
                    else if (s.grp_on[wr_sel])
                    begin
                        next_s.out_active = 1'b0; // R10
                    end
                    // off on an already-off group leaves the output alone; only its divisor is stored
                end
                `RCD_RESET_CMD:
                begin
                    if (avs_writedata[`RCD_BASE_RST_BIT])
                        next_s = base_reset(next_s); // R5
                    else if (avs_writedata[`RCD_PART_RST_BIT])
                    begin
                        // groups only; reference left running
                        next_s.grp_on = '0; // R7
                        next_s.grp_div = '0;
                        next_s.grp_sel = '0;
                        next_s.owner = '0;
                        next_s.out_active = 1'b0;
                    end
                end
                default: ; // read-only or unmapped: ignored
            endcase
        end
    end
    // ----------------------------------------------------------
    // registers; async reset also selects internal reference
    // ----------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            s <= RST; // R5
        else
            s <= next_s;
    end
    // ----------------------------------------------------------
    // second output divider
    // ----------------------------------------------------------
    assign dv.run = s.out_active;
    assign dv.div_m1 = s.grp_div[s.owner]; // R11
    rcd_divider u_div (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .dv(dv)
    );
    // outputs, all straight from flops
    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.wait_req;
    assign ref_out1 = s.ref_out1;
    assign ref_out2 = dv.level;
    assign ref_out2_tick = dv.tick;
    assign unlock_warn = s.warn;
    assign unlocked = s.unlocked;
    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    base_rst_int_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R5
        acc && avs_write && avs_address == `RCD_RESET_CMD && avs_writedata[0]
        |=> !s.ref_ext ##1 s.lck == RCD_INT)
        else $error("base reset left external reference");
    part_rst_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
        acc && avs_write && avs_address == `RCD_RESET_CMD && avs_writedata[1:0] == 2'b10
        |=> $stable(s.ref_ext) && !s.out_active)
        else $error("partial reset touched reference");
    out1_follow_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
        ##1 ref_out1 == ($past(s.ref_ext) ? $past(s.ext_sync[1]) : $past(s.int_sync[1])))
        else $error("first output not the selected reference");
    settle_bound_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
        s.lck == RCD_SETTLE |-> s.settle_cnt < SETTLE_CYC && s.ref_ext == 1'b1 || !s.ref_ext)
        else $error("settling counter overran");
    unlock_cause_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
        $rose(s.unlocked) |-> $past(s.lck) != RCD_INT && $past(s.ref_ext))
        else $error("unlock flag without external reference");
    status_bit_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
        req && s.wait_req && avs_address == `RCD_OP_STATUS
        |=> avs_readdata[6] == $past(s.unlocked) && !avs_waitrequest)
        else $error("status bit six wrong");
    out2_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R10
        acc && avs_write && avs_address == `RCD_OUT2_CTRL && !wr_on && s.grp_on[wr_sel]
        |=> !s.out_active ##1 !ref_out2)
        else $error("clock not removed on explicit off");
    out2_on_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
        acc && avs_write && avs_address == `RCD_OUT2_CTRL && wr_on
        |=> s.out_active && s.owner == $past(wr_sel))
        else $error("group on did not take the output");
    off_keeps_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R9
        acc && avs_write && avs_address == `RCD_OUT2_CTRL && !wr_on && !s.grp_on[wr_sel]
        |=> $stable(s.out_active) && $stable(s.owner))
        else $error("off on idle group disturbed output");
endmodule : rcd_ref_clock
`default_nettype wire

// ---- verification/rcd_ref_source.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------
// external reference source
// ----------------------------------------------------------
module rcd_ref_source (
    input wire logic clk_sys,
    input wire logic src_on,
    input wire logic [7:0] half_cyc,
    output logic ext_ref_in
);
    logic [7:0] cnt; // cycles into the current half period
    initial
    begin
        cnt = 8'h00;
        ext_ref_in = 1'b0;
    end
    // square wave of two half periods; a missing source sits low, no edges
    always @(posedge clk_sys)
    begin
        if (!src_on)
        begin
            cnt <= 8'h00;
            ext_ref_in <= 1'b0;
        end
        else if (cnt >= half_cyc - 8'h01)
        begin
            cnt <= 8'h00;
            ext_ref_in <= ~ext_ref_in;
        end
        else
            cnt <= cnt + 8'h01;
    end
endmodule : rcd_ref_source
`default_nettype wire

// ---- verification/reference_clock_select_divider_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "rcd_map.svh"
module reference_clock_select_divider_tb;
    // ----------------------------------------------------------
    // signals
    // ----------------------------------------------------------
    localparam int LIMIT = 20000; // whole run needs about 1400 cycles
    logic clk_sys, resetn, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic ext_ref_in, int_osc_in, ref_out1, ref_out2, ref_out2_tick, unlock_warn, unlocked;
    logic src_on;
    logic [7:0] half_cyc;
    int errors, checked, cyc, run_iv, run_hi, last_iv, last_hi, k;
    int divs[3] = '{2, 7, 32};
    // short counts so settling, gating and warnings fit in the run
    rcd_ref_clock #(.NGROUP(4), .SETTLE_CYC(50), .GATE_CYC(40), .WARN_CYC(20)) u_dut (
        .clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_ref_in(ext_ref_in), .int_osc_in(int_osc_in),
        .ref_out1(ref_out1), .ref_out2(ref_out2), .ref_out2_tick(ref_out2_tick),
        .unlock_warn(unlock_warn), .unlocked(unlocked));
    // far side: 2-cycle half period gives 10 edges per 40-cycle gate
    rcd_ref_source u_src (.clk_sys(clk_sys), .src_on(src_on), .half_cyc(half_cyc),
        .ext_ref_in(ext_ref_in));
    // ----------------------------------------------------------
    // clock, oscillator, interval watch, timeout
    // ----------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // internal oscillator at 10 MHz: one toggle per system cycle
    always @(posedge clk_sys) int_osc_in <= ~int_osc_in;
    // length and high time of each divider period, measured between ticks
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (ref_out2_tick === 1'b1)
        begin
            last_iv <= run_iv;
            last_hi <= run_hi;
            run_iv <= 1;
            run_hi <= int'(ref_out2 === 1'b1);
        end
        else
        begin
            run_iv <= run_iv + 1;
            run_hi <= run_hi + int'(ref_out2 === 1'b1);
        end
        if (cyc == LIMIT)
        begin
            errors++;
            close_out;
        end
    end
    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one Avalon transfer; request held until waitrequest is sampled low
    task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= rd;
        avs_write <= ~rd;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50)
            errors++;
    endtask : bus
    task automatic wr(input logic [4:0] a, input logic [31:0] wd);
        bus(1'b0, a, wd);
    endtask : wr
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b1, a, 32'h0000_0000);
        chk(d, exp);
    endtask : rd_chk
    // toggles of ref_out1 over n cycles
    task automatic count_tog(input int n);
        logic p;
        k = 0;
        @(posedge clk_sys);
        p = ref_out1;
        repeat (n)
        begin
            @(posedge clk_sys);
            k += int'(ref_out1 !== p);
            p = ref_out1;
        end
    endtask : count_tog
    // high cycles of ref_out2 (w=0) or unlock_warn (w=1) over n cycles
    task automatic count_hi(input logic w, input int n);
        k = 0;
        repeat (n)
        begin
            @(posedge clk_sys);
            k += int'((w ? unlock_warn : ref_out2) === 1'b1);
        end
    endtask : count_hi
    // bounded wait for a divider reload, plus one edge for the watch to land
    task automatic wait_tick;
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (ref_out2_tick !== 1'b1 && n < 100);
        if (n >= 100)
            errors++;
        @(posedge clk_sys);
    endtask : wait_tick
    task automatic two_ticks(input int n);
        wait_tick;
        wait_tick;
        wait_tick;
        chk(last_iv, n);
        chk(last_hi, (n + 1) / 2);
    endtask : two_ticks
    task automatic close_out;
        if (errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    // reset state, read-only and unmapped places
    task automatic t_reset;
        rd_chk(`RCD_REF_CTRL, 32'h0000_0000);
        rd_chk(`RCD_REF_NOMINAL, 32'h0000_2710);
        wr(5'h1E, 32'hFFFF_FFFF);
        wr(`RCD_OP_STATUS, 32'hFFFF_FFFF);
        rd_chk(5'h1E, 32'h0000_0000);
        rd_chk(`RCD_OP_STATUS, 32'h0000_0000);
        rd_chk(`RCD_LOCK_QUERY, 32'h0000_0000);
        rd_chk(`RCD_OUT2_STATUS, 32'h0000_0000);
        count_tog(20);
        chk(k, 20);
        chk(ref_out2, 1'b0);
    endtask : t_reset
    // external selection, settling, then lock
    task automatic t_ext;
        src_on <= 1'b1;
        wr(`RCD_REF_NOMINAL, 32'h0000_000A);
        wr(`RCD_REF_CTRL, 32'h0000_0001);
        rd_chk(`RCD_OP_STATUS, 32'h0000_0001);
        rd_chk(`RCD_LOCK_QUERY, 32'h0000_0001);
        repeat (20) @(posedge clk_sys);
        chk(unlocked, 1'b1);
        repeat (200) @(posedge clk_sys);
        rd_chk(`RCD_OP_STATUS, 32'h0000_0000);
        rd_chk(`RCD_REF_CTRL, 32'h0000_0001);
        count_tog(40);
        chk(k, 20);
        count_hi(1'b1, 100);
        chk(k, 0);
    endtask : t_ext
    // second output: divisors, reload timing, group ownership
    task automatic t_groups;
        wr(`RCD_GROUP_SEL, 32'h0000_0000);
        wr(`RCD_OUT2_CTRL, 32'h0000_0301);
        rd_chk(`RCD_OUT2_STATUS, 32'h0000_0100);
        two_ticks(4);
        foreach (divs[i])
        begin
            wr(`RCD_OUT2_CTRL, 32'((divs[i] - 1) << 8) | 32'h0000_0001);
            two_ticks(divs[i]);
        end
        wait_tick;
        wr(`RCD_OUT2_CTRL, 32'h0000_0401);
        wait_tick;
        chk(last_iv, 32);
        wait_tick;
        chk(last_iv, 5);
        wr(`RCD_OUT2_CTRL, 32'h0000_0001);
        two_ticks(1);
        wr(`RCD_GROUP_SEL, 32'h0000_0001);
        wr(`RCD_OUT2_CTRL, 32'h0000_0401);
        rd_chk(`RCD_OUT2_STATUS, 32'h0000_0101);
        two_ticks(5);
        wr(`RCD_GROUP_SEL, 32'h0000_0002);
        wr(`RCD_OUT2_CTRL, 32'h0000_0000);
        rd_chk(`RCD_OUT2_STATUS, 32'h0000_0101);
        two_ticks(5);
        rd_chk(`RCD_REF_CTRL, 32'h0000_0001);
        wr(`RCD_GROUP_SEL, 32'h0000_0000);
        wr(`RCD_OUT2_CTRL, 32'h0000_0000);
        bus(1'b1, `RCD_OUT2_STATUS, 32'h0000_0000);
        chk(d[8], 1'b0);
        count_hi(1'b0, 40);
        chk(k, 0);
        wr(`RCD_GROUP_SEL, 32'h0000_0007);
        wr(`RCD_OUT2_CTRL, 32'h0000_0201);
        rd_chk(`RCD_OUT2_STATUS, 32'h0000_0103);
        rd_chk(`RCD_REF_CTRL, 32'h0000_0001);
        two_ticks(3);
    endtask : t_groups
    // missing source: flag, query and repeating warning
    task automatic t_unlock;
        src_on <= 1'b0;
        repeat (120) @(posedge clk_sys);
        chk(unlocked, 1'b1);
        rd_chk(`RCD_OP_STATUS, 32'h0000_0040);
        rd_chk(`RCD_LOCK_QUERY, 32'h0000_0001);
        count_hi(1'b1, 100);
        chk(k, 5);
        src_on <= 1'b1;
        repeat (120) @(posedge clk_sys);
        chk(unlocked, 1'b0);
    endtask : t_unlock
    // partial, base and pin resets
    task automatic t_resets;
        wr(`RCD_RESET_CMD, 32'h0000_0002);
        rd_chk(`RCD_OP_STATUS, 32'h0000_0000);
        rd_chk(`RCD_REF_CTRL, 32'h0000_0001);
        bus(1'b1, `RCD_OUT2_STATUS, 32'h0000_0000);
        chk(d[8], 1'b0);
        wr(`RCD_RESET_CMD, 32'h0000_0001);
        rd_chk(`RCD_REF_CTRL, 32'h0000_0000);
        rd_chk(`RCD_REF_NOMINAL, 32'h0000_000A);
        count_tog(20);
        chk(k, 20);
        wr(`RCD_REF_CTRL, 32'h0000_0001);
        rd_chk(`RCD_OP_STATUS, 32'h0000_0001);
        repeat (200) @(posedge clk_sys);
        chk(unlocked, 1'b0);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        rd_chk(`RCD_REF_CTRL, 32'h0000_0000);
        rd_chk(`RCD_REF_NOMINAL, 32'h0000_2710);
    endtask : t_resets
    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial
    begin
        {resetn, avs_read, avs_write, int_osc_in, src_on} = 5'h00;
        avs_address = 5'h00;
        avs_writedata = 32'h0000_0000;
        half_cyc = 8'h02;
        {errors, checked, cyc, run_iv, run_hi, last_iv, last_hi} = '0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset;
        t_ext;
        t_groups;
        t_unlock;
        t_resets;
        close_out;
    end
endmodule : reference_clock_select_divider_tb
`default_nettype wire
